//--- core/tfc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef TFC_MAP_SVH
`define TFC_MAP_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define TFC_IDX_TEMP     10'h020
`define TFC_IDX_NV       10'h030
`define TFC_IDX_OFFS     10'h031
`define TFC_IDX_COEF     10'h032
`define TFC_IDX_T0       10'h033
`define TFC_IDX_STAT     10'h034
`define TFC_IDX_COMP     10'h035

// ************************************************************
// field positions
// ************************************************************
`define TFC_NV_THERM_EN  1
`define TFC_NV_SCAN_SEL  0
`define TFC_OFFS_SIGN    7

// ************************************************************
// reset values
// ************************************************************
`define TFC_RST_TEMP     8'h55
`define TFC_RST_NV       8'h00
`define TFC_RST_OFFS     8'h00
`define TFC_RST_COEF     8'h96
`define TFC_RST_T0       6'h15

// ************************************************************
// coding and timing
// ************************************************************
`define TFC_TEMP_MAX     8'hfa
`define TFC_DT_BIAS      11'sh040
`define TFC_PPM_SCALE    25'h00003d
`define TFC_MAG_MAX      10'h3ff
`define TFC_REF_HZ       32768
`define TFC_PERIOD_S     32
`define TFC_SLOTS        1024

`endif

//--- core/tfc_pkg.sv
// state types of the compensation block
package tfc_pkg;

	typedef struct packed {
		logic        xs1;
		logic        xs2;
		logic        xprev;
		logic        ref_pulse;
		logic        lv1a;
		logic        lv1b;
		logic        lv2a;
		logic        lv2b;
		logic [7:0]  sa;
		logic [7:0]  sb;
		logic [7:0]  temp;
		logic [7:0]  nv;
		logic [7:0]  offs;
		logic [7:0]  coef;
		logic [5:0]  t0;
		logic        flag1;
		logic        flag2;
		logic        frozen;
		logic [9:0]  cmag;
		logic        cins;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} tfc_state_t;

	typedef struct packed {
		logic [16:0] cnt;
		logic [15:0] slot;
		logic [9:0]  acc;
		logic        pending;
		logic [4:0]  sec;
		logic        tick;
		logic        pstart;
	} corr_state_t;

endpackage

//--- core/comp_calc.sv
// compensation value from crystal parameters and temperature
`include "tfc_map.svh"

module comp_calc (
	input  wire logic [7:0] temp_i,
	input  wire logic [7:0] offset_i,
	input  wire logic [7:0] coef_i,
	input  wire logic [5:0] turnover_i,
	output logic      [9:0] corr_mag_o,
	output logic            corr_insert_o
);

	always_comb begin
		logic signed [10:0] dt;
		logic        [9:0]  adt;
		logic        [19:0] sq;
		logic        [27:0] prod;
		logic signed [18:0] c;
		logic        [18:0] ac;
		logic        [24:0] sc;
		dt = '0;
		adt = '0;
		sq = '0;
		prod = '0;
		c = '0;
		ac = '0;
		sc = '0;
		// temp-60 minus turnover+4
		dt = $signed({3'h0, temp_i}) - $signed({5'h0, turnover_i})
			- `TFC_DT_BIAS;
		adt = dt[10] ? 10'(-dt) : dt[9:0];
		sq = adt * adt;
		// quadratic drift always slows the crystal
		prod = coef_i * sq;
		// sign 1 means fast, so its offset is taken off
		if (offset_i[`TFC_OFFS_SIGN])
			c = $signed({3'h0, prod[27:12]})
				- $signed({12'h0, offset_i[6:0]});
		else
			c = $signed({3'h0, prod[27:12]})
				+ $signed({12'h0, offset_i[6:0]});
		ac = c[18] ? 19'(-c) : c;
		// register units carry a 1.05 factor, undone as 61/64
		sc = {6'h00, ac} * `TFC_PPM_SCALE;
		corr_mag_o = (|sc[24:16]) ? `TFC_MAG_MAX : sc[15:6];
		corr_insert_o = ~c[18];
	end

endmodule

//--- core/pulse_corrector.sv
// prescaler with inserted or removed reference pulses
`include "tfc_map.svh"

module pulse_corrector #(
	parameter int SEC_REFS  = `TFC_REF_HZ,
	parameter int SLOT_REFS = (`TFC_PERIOD_S * SEC_REFS) / `TFC_SLOTS
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ref_pulse_i,
	input  wire logic [9:0] comp_mag_i,
	input  wire logic       comp_insert_i,
	output logic            second_tick_o,
	output logic            period_start_o,
	output logic      [4:0] second_count_o
);

	tfc_pkg::corr_state_t s;
	tfc_pkg::corr_state_t next_s;

	always_comb begin
		logic [17:0] sum;
		logic [10:0] asum;
		logic [1:0]  step;
		sum = '0;
		asum = '0;
		step = 2'h1;
		next_s = s;
		next_s.tick = 1'b0;
		next_s.pstart = 1'b0;
		if (ref_pulse_i) begin
			// one pulse more or one less, never the oscillator
			if (s.pending) begin
				step = comp_insert_i ? 2'h2 : 2'h0;
				next_s.pending = 1'b0;
			end
			sum = {1'b0, s.cnt} + {16'h0000, step};
			if (sum >= 18'(SEC_REFS)) begin
				next_s.cnt = 17'(sum - 18'(SEC_REFS));
				next_s.tick = 1'b1;
				next_s.sec = s.sec + 5'h01;
				next_s.pstart = (s.sec == 5'h1f);
			end else begin
				next_s.cnt = sum[16:0];
			end
			// corrections spread evenly over the 32 s period
			if (s.slot == 16'(SLOT_REFS - 1)) begin
				next_s.slot = '0;
				asum = {1'b0, s.acc} + {1'b0, comp_mag_i};
				next_s.acc = asum[9:0];
				if (asum[10])
					next_s.pending = 1'b1;
			end else begin
				next_s.slot = s.slot + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign second_tick_o = s.tick;
	assign period_start_o = s.pstart;
	assign second_count_o = s.sec;

endmodule

//--- core/temp_frequency_compensation.sv
// temperature compensation top: registers, thermometer, freeze, FREQUENCY_COMPENSATION_UNIT
// ************************************************************
// ************************************************************
`include "tfc_map.svh"

module temp_frequency_compensation #(
	parameter int SEC_REFS = `TFC_REF_HZ
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        xtal_clk_i,
	input  wire logic [7:0]  sensor_code_i,
	input  wire logic        low_supply_status_one_i,
	input  wire logic        low_supply_status_two_i,
	output logic             second_tick_o
);

	localparam tfc_pkg::tfc_state_t RST = '{
		temp: `TFC_RST_TEMP,
		nv: `TFC_RST_NV,
		offs: `TFC_RST_OFFS,
		coef: `TFC_RST_COEF,
		t0: `TFC_RST_T0,
		default: '0
	};

	tfc_pkg::tfc_state_t s;
	tfc_pkg::tfc_state_t next_s;

	logic       tick;
	logic       pstart;
	logic [4:0] sec;
	logic [9:0] calc_mag;
	logic       calc_ins;
	logic       setup;
	logic       acc_wr;
	logic [9:0] idx;
	logic       meas;
	logic       therm_en;
	logic [7:0] clamped;

	// ************************************************************
	// sub-blocks
	// ************************************************************
	comp_calc u_calc (
		.temp_i        (s.temp),
		.offset_i      (s.offs),
		.coef_i        (s.coef),
		.turnover_i    (s.t0),
		.corr_mag_o    (calc_mag),
		.corr_insert_o (calc_ins)
	);

	pulse_corrector #(
		.SEC_REFS (SEC_REFS)
	) u_corr (
		.clk_i          (clk_i),
		.rst_n_i        (rst_n_i),
		.ref_pulse_i    (s.ref_pulse),
		.comp_mag_i     (s.cmag),
		.comp_insert_i  (s.cins),
		.second_tick_o  (tick),
		.period_start_o (pstart),
		.second_count_o (sec)
	);

	// ************************************************************
	// decode
	// ************************************************************
	assign setup = psel_i & ~penable_i;
	// a misaligned write is answered with an error and never lands
	assign acc_wr = psel_i & penable_i & s.pready & pwrite_i
		& (paddr_i[1:0] == 2'h0);
	assign idx = paddr_i[11:2];
	assign therm_en = s.nv[`TFC_NV_THERM_EN];
	assign clamped = (s.sb > `TFC_TEMP_MAX) ? `TFC_TEMP_MAX : s.sb;
	// no scan while disabled, frozen or supply low
	assign meas = tick & therm_en & ~s.frozen & ~s.lv1b
		& (~s.nv[`TFC_NV_SCAN_SEL] | (sec[3:0] == 4'h0));

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_s = s;
		// xtal edge becomes a one-cycle reference pulse
		next_s.xs1 = xtal_clk_i;
		next_s.xs2 = s.xs1;
		next_s.xprev = s.xs2;
		next_s.ref_pulse = s.xs2 & ~s.xprev;
		next_s.lv1a = low_supply_status_one_i;
		next_s.lv1b = s.lv1a;
		next_s.lv2a = low_supply_status_two_i;
		next_s.lv2b = s.lv2a;
		// sensor code must be held steady across a sample
		next_s.sa = sensor_code_i;
		next_s.sb = s.sa;

		if (meas)
			next_s.temp = clamped;

		// register writes land on the access edge
		if (acc_wr) begin
			case (idx)
				`TFC_IDX_TEMP:
					if (!therm_en)
						next_s.temp = pwdata_i[7:0];
				`TFC_IDX_NV:   next_s.nv = pwdata_i[7:0];
				`TFC_IDX_OFFS: next_s.offs = pwdata_i[7:0];
				`TFC_IDX_COEF: next_s.coef = pwdata_i[7:0];
				`TFC_IDX_T0:   next_s.t0 = pwdata_i[5:0];
				`TFC_IDX_STAT: begin
					// write zero clears, write one is ignored
					next_s.flag1 = s.flag1 & pwdata_i[0];
					next_s.flag2 = s.flag2 & pwdata_i[1];
				end
				default: ;
			endcase
		end

		// hardware set wins over the software clear
		if (s.lv1b)
			next_s.flag1 = 1'b1;
		if (s.lv2b)
			next_s.flag2 = 1'b1;

		if (s.lv1b)
			next_s.frozen = 1'b1;
		else if (!s.flag1 && !s.flag2)
			next_s.frozen = 1'b0;

		// latch a fresh value once per 32 s period
		if (pstart) begin
			next_s.cmag = calc_mag;
			next_s.cins = calc_ins;
		end

		// zero-wait slave: data and answer prepared in setup
		next_s.pready = setup;
		next_s.pslverr = 1'b0;
		if (setup) begin
			next_s.prdata = '0;
			case (idx)
				`TFC_IDX_TEMP: next_s.prdata[7:0] = s.temp;
				`TFC_IDX_NV:   next_s.prdata[7:0] = s.nv;
				`TFC_IDX_OFFS: next_s.prdata[7:0] = s.offs;
				`TFC_IDX_COEF: next_s.prdata[7:0] = s.coef;
				`TFC_IDX_T0:   next_s.prdata[5:0] = s.t0;
				`TFC_IDX_STAT:
					next_s.prdata[2:0] = {s.frozen, s.flag2, s.flag1};
				`TFC_IDX_COMP:
					next_s.prdata[10:0] = {s.cins, s.cmag};
				default: next_s.pslverr = 1'b1;
			endcase
			if (paddr_i[1:0] != 2'h0)
				next_s.pslverr = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			s <= RST;
		else
			s <= next_s;
	end

	assign prdata_o = s.prdata;
	assign pready_o = s.pready;
	assign pslverr_o = s.pslverr;
	assign second_tick_o = tick;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_meas_stores_code: assert property (
		meas |=> s.temp == $past(clamped))
		else $error("measurement not stored");

	a_temp_write_lock: assert property (
		acc_wr && idx == `TFC_IDX_TEMP && therm_en && !meas
		|=> $stable(s.temp))
		else $error("temperature written while enabled");

	a_disabled_holds: assert property (
		!therm_en && !acc_wr |=> $stable(s.temp))
		else $error("temperature changed while disabled");

	a_long_scan_slot: assert property (
		meas && s.nv[`TFC_NV_SCAN_SEL] |-> sec[3:0] == 4'h0)
		else $error("16 s scan off its slot");

	a_low_freezes: assert property (
		s.lv1b |=> s.frozen ##1 (s.frozen && !meas))
		else $error("low supply did not freeze");

	a_frozen_holds: assert property (
		s.frozen && therm_en |=> $stable(s.temp))
		else $error("frozen reading moved");

	a_resume_clear: assert property (
		s.frozen && !s.lv1b && !s.flag1 && !s.flag2 |=> !s.frozen)
		else $error("freeze not released");

	a_stay_frozen: assert property (
		s.frozen && s.flag1 |=> s.frozen)
		else $error("freeze left with flag set");

	a_period_latch: assert property (
		pstart |=> s.cmag == $past(calc_mag) && s.cins == $past(calc_ins))
		else $error("period value not latched");

	a_value_steady: assert property (
		!pstart |=> $stable(s.cmag))
		else $error("value changed mid period");

	a_ready_pulse: assert property (
		setup |=> s.pready ##1 !s.pready)
		else $error("apb ready not one cycle");

	// ************************************************************
	// register and scan checks
	// ************************************************************
	a_nv_write_lands: assert property (
		acc_wr && idx == `TFC_IDX_NV |=> s.nv == $past(pwdata_i[7:0]))
		else $error("settings write lost");

	a_offs_write_lands: assert property (
		acc_wr && idx == `TFC_IDX_OFFS |=> s.offs == $past(pwdata_i[7:0]))
		else $error("offset write lost");

	a_coef_write_lands: assert property (
		acc_wr && idx == `TFC_IDX_COEF |=> s.coef == $past(pwdata_i[7:0]))
		else $error("coefficient write lost");

	a_t0_write_lands: assert property (
		acc_wr && idx == `TFC_IDX_T0 |=> s.t0 == $past(pwdata_i[5:0]))
		else $error("turnover write lost");

	a_temp_sw_write: assert property (
		acc_wr && idx == `TFC_IDX_TEMP && !therm_en
		|=> s.temp == $past(pwdata_i[7:0]))
		else $error("temperature write lost while disabled");

	a_code_in_range: assert property (
		meas |=> s.temp <= `TFC_TEMP_MAX)
		else $error("stored code above limit");

	a_flag_one_set: assert property (
		s.lv1b |=> s.flag1)
		else $error("first low flag not set");

	a_flag_two_set: assert property (
		s.lv2b |=> s.flag2)
		else $error("second low flag not set");

	a_flag_one_holds: assert property (
		s.flag1 && !(acc_wr && idx == `TFC_IDX_STAT) |=> s.flag1)
		else $error("first low flag dropped by itself");

	a_no_scan_frozen: assert property (
		s.frozen |-> !meas)
		else $error("scan while frozen");

	a_no_scan_off: assert property (
		!therm_en |-> !meas)
		else $error("scan while disabled");

	a_low_blocks_scan: assert property (
		s.lv1b |-> !meas)
		else $error("scan while supply low");

	a_short_scan: assert property (
		tick && therm_en && !s.frozen && !s.lv1b
		&& !s.nv[`TFC_NV_SCAN_SEL] |-> meas)
		else $error("1 s scan missed");

	a_misaligned_err: assert property (
		setup && paddr_i[1:0] != 2'h0 |=> s.pslverr)
		else $error("misaligned access without error");

	a_misaligned_drop: assert property (
		psel_i && penable_i && pwrite_i && paddr_i[1:0] != 2'h0
		|=> $stable(s.nv) && $stable(s.offs))
		else $error("misaligned write landed");

	a_unmapped_err: assert property (
		setup && idx > `TFC_IDX_COMP |=> s.pslverr)
		else $error("unmapped access without error");

	a_unmapped_zero: assert property (
		setup && idx > `TFC_IDX_COMP |=> s.prdata == 32'h0)
		else $error("unmapped read not zero");

	a_read_temp: assert property (
		setup && idx == `TFC_IDX_TEMP |=> s.prdata[7:0] == $past(s.temp))
		else $error("temperature read wrong");

	a_read_comp: assert property (
		setup && idx == `TFC_IDX_COMP |=> s.prdata[9:0] == $past(s.cmag))
		else $error("compensation read wrong");

	a_stat_read: assert property (
		setup && idx == `TFC_IDX_STAT
		|=> s.prdata[0] == $past(s.flag1) && s.prdata[2] == $past(s.frozen))
		else $error("status read wrong");

	a_ready_idle: assert property (
		!setup |=> !s.pready)
		else $error("ready without setup");

	a_ref_single: assert property (
		s.ref_pulse |=> !s.ref_pulse)
		else $error("reference pulse longer than one cycle");

	a_tick_one_cycle: assert property (
		tick |=> !tick)
		else $error("second tick longer than one cycle");

	c_measure: cover property (meas);
	c_freeze_resume: cover property (s.frozen ##[1:200] !s.frozen);
	c_insert_period: cover property (pstart ##1 (s.cins && s.cmag != 0));
	c_remove_period: cover property (pstart ##1 (!s.cins && s.cmag != 0));

endmodule

//--- verif/temp_frequency_compensation_tb_top.sv
// self-checking bench of the temperature compensation block
`include "tfc_map.svh"

module temp_frequency_compensation_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin mismatches++; \
	$display("Error at %0t: got %h expected %h", $time, g, x); end end

	// ************************************************************
	// signals and model
	// ************************************************************
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        xtal = 1'b0;
	logic [7:0]  sensor = 8'h3c;
	logic        lv1 = 1'b0;
	logic        lv2 = 1'b0;
	logic        tick;
	logic [2:0]  xdiv = 3'h0;
	logic [31:0] mdl[logic [9:0]];
	logic [31:0] r;
	logic [31:0] v;
	logic        e;
	int          mismatches = 0;
	int          n_checks = 0;
	int          seed = 4981;
	int          ticks = 0;
	int          pulses = 0;
	int          sec_q[$];
	int          k;

	always #12.5 clk = ~clk;

	// slot of 2 reference pulses keeps a 32 s period at 2048 pulses
	temp_frequency_compensation #(.SEC_REFS(64)) i_dut (
		.clk_i                   (clk),
		.rst_n_i                 (rst_n),
		.psel_i                  (psel),
		.penable_i               (penable),
		.pwrite_i                (pwrite),
		.paddr_i                 (paddr),
		.pwdata_i                (pwdata),
		.prdata_o                (prdata),
		.pready_o                (pready),
		.pslverr_o               (pslverr),
		.xtal_clk_i              (xtal),
		.sensor_code_i           (sensor),
		.low_supply_status_one_i (lv1),
		.low_supply_status_two_i (lv2),
		.second_tick_o           (tick)
	);

	// oscillator at one eighth of the system clock; pulses per second
	always @(posedge clk) begin
		xdiv <= xdiv + 3'h1;
		xtal <= xdiv[2];
		if (tick === 1'b1) begin
			sec_q.push_back(pulses);
			pulses = 0;
			ticks++;
		end
		if (xdiv == 3'h4)
			pulses++;
	end

	// ************************************************************
	// bus and helper tasks
	// ************************************************************
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] i);
		apb(1'b0, {i, 2'b00}, 32'h0);
		`CHK(e, 1'b0)
		`CHK(r, mdl[i])
	endtask

	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		apb(1'b1, {i, 2'b00}, d);
		`CHK(e, 1'b0)
		case (i)
			`TFC_IDX_TEMP: if (!mdl[`TFC_IDX_NV][1]) mdl[i] = d[7:0];
			`TFC_IDX_T0:   mdl[i] = {26'h0, d[5:0]};
			`TFC_IDX_STAT, `TFC_IDX_COMP: ;
			default:       mdl[i] = {24'h0, d[7:0]};
		endcase
	endtask

	task automatic waitt(input int n);
		int t;
		t = ticks + n;
		while (ticks < t)
			@(posedge clk);
		repeat (3) @(posedge clk);
	endtask

	// seconds until the register shows a new sensor code
	task automatic ticks_until(input logic [7:0] c);
		sensor <= c;
		k = 0;
		do begin
			waitt(1);
			apb(1'b0, {`TFC_IDX_TEMP, 2'b00}, 32'h0);
			k++;
		end while (r[7:0] !== c && k < 40);
		mdl[`TFC_IDX_TEMP] = {24'h0, c};
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		mdl[`TFC_IDX_TEMP] = `TFC_RST_TEMP;
		mdl[`TFC_IDX_NV]   = `TFC_RST_NV;
		mdl[`TFC_IDX_OFFS] = `TFC_RST_OFFS;
		mdl[`TFC_IDX_COEF] = `TFC_RST_COEF;
		mdl[`TFC_IDX_T0]   = `TFC_RST_T0;
		mdl[`TFC_IDX_STAT] = 32'h0;
		mdl[`TFC_IDX_COMP] = 32'h0;
		foreach (mdl[i]) rd(i);
		apb(1'b0, 12'h000, 32'h0);
		`CHK({e, r}, 33'h100000000)
		apb(1'b1, {`TFC_IDX_TEMP, 2'b01}, 32'h0);
		`CHK(e, 1'b1)
		wr(`TFC_IDX_COMP, 32'hffff);
		rd(`TFC_IDX_COMP);
		repeat (4) begin
			v = $random(seed);
			wr(`TFC_IDX_OFFS, v);
			wr(`TFC_IDX_COEF, v >> 8);
			wr(`TFC_IDX_T0, v >> 16);
			foreach (mdl[i]) rd(i);
		end
		// one second scan, software write refused while measuring
		wr(`TFC_IDX_NV, 32'h2);
		ticks_until(8'h64);
		`CHK(k, 1)
		wr(`TFC_IDX_TEMP, 32'h11);
		rd(`TFC_IDX_TEMP);
		sensor <= 8'hff;
		waitt(1);
		mdl[`TFC_IDX_TEMP] = 32'hfa;
		rd(`TFC_IDX_TEMP);
		`CHK(sec_q[1], 64)
		// supply low: freeze, then resume only with both flags clear
		lv1 <= 1'b1;
		repeat (5) @(posedge clk);
		mdl[`TFC_IDX_STAT] = 32'h5;
		rd(`TFC_IDX_STAT);
		sensor <= 8'h22;
		waitt(2);
		rd(`TFC_IDX_TEMP);
		lv1 <= 1'b0;
		lv2 <= 1'b1;
		repeat (5) @(posedge clk);
		wr(`TFC_IDX_STAT, 32'h0);
		mdl[`TFC_IDX_STAT] = 32'h6;
		rd(`TFC_IDX_STAT);
		lv2 <= 1'b0;
		repeat (5) @(posedge clk);
		wr(`TFC_IDX_STAT, 32'h0);
		repeat (2) @(posedge clk);
		mdl[`TFC_IDX_STAT] = 32'h0;
		rd(`TFC_IDX_STAT);
		ticks_until(8'h22);
		`CHK(k, 1)
		// sixteen second scan
		wr(`TFC_IDX_NV, 32'h3);
		ticks_until(8'h40);
		ticks_until(8'h41);
		`CHK(k, 16)
		wr(`TFC_IDX_NV, 32'h0);
		sensor <= 8'h33;
		waitt(1);
		rd(`TFC_IDX_TEMP);
		// slow crystal at turnover: 64 * 61 / 64 pulses inserted
		wr(`TFC_IDX_T0, 32'h15);
		wr(`TFC_IDX_TEMP, 32'h55);
		wr(`TFC_IDX_OFFS, 32'h40);
		waitt(33);
		mdl[`TFC_IDX_COMP] = 32'h43d;
		rd(`TFC_IDX_COMP);
		sec_q.delete();
		waitt(32);
		k = 0;
		foreach (sec_q[j]) k += sec_q[j];
		`CHK(k >= 1986 && k <= 1988, 1'b1)
		// fast crystal, dT 32: drift 16 minus offset 80, removed
		wr(`TFC_IDX_OFFS, 32'hd0);
		wr(`TFC_IDX_COEF, 32'h40);
		wr(`TFC_IDX_TEMP, 32'h75);
		waitt(33);
		mdl[`TFC_IDX_COMP] = 32'h03d;
		rd(`TFC_IDX_COMP);
		tally_and_finish();
	end

endmodule
